// >>> logic/dsu_left_lanes.sv
// Byte lane and data placement for the left-part store.
// Assumes lane i holds memory byte i of the aligned doubleword in little-endian numbering.
`timescale 1ns/1ps
module dsu_left_lanes (
  // Address and order
  input  wire logic [2:0]  low_addr,
  input  wire logic        core_order_big_flag,
  // Source and result
  input  wire logic [63:0] src,
  output logic      [63:0] data,
  output logic      [7:0]  lanes
);
  logic [2:0] bytesel;
  // Lane index in little-endian terms; big-endian mirrors the offset
  assign bytesel = low_addr ^ {3{core_order_big_flag}};
  always_comb
  begin
    // Top bytesel+1 source bytes land in lanes 0..bytesel
    data  = src >> (6'(7 - bytesel) * 6'd8);
    lanes = 8'((9'h2 << bytesel) - 9'h1);
  end
endmodule

// >>> logic/dsu_pkg.sv
// Constants and types shared by the doubleword store unit.
// Assumes a 64-bit core with a translation stage and a byte-lane store port.
// Overview of operation
// - Integer doubleword store writes all 64 source register bits at aligned address.
// - Effective address is base plus sign-extended 16-bit offset.
// - Integer store misaligned in low three bits raises address error, no write.
// - Integer store exceptions: refill, invalid, modified, address error, reserved, watch.
// - Float store writes the float register's 64 bits uninterpreted at aligned address.
// - Both coprocessor stores raise address error when low three bits nonzero.
// - Coprocessor stores may also raise coprocessor unusable.
// - Coprocessor-2 store writes register select 0 as 64 bits, aligned.
// - Left-part store treats address as most significant byte of an unaligned doubleword.
// - Left-part store writes top 1 to 8 source bytes within the aligned doubleword.
// - Left-part lanes follow low three address bits and core byte order.
// - Left-part physical low bits xor swap flag, zeroed when memory little-endian.
package dsu_pkg;
  localparam logic [5:0] OP_STORE_DW  = 6'h3f;
  localparam logic [5:0] OP_FLOAT_DW  = 6'h3d;
  localparam logic [5:0] OP_COP2_DW   = 6'h3e;
  localparam logic [5:0] OP_LEFT_PART = 6'h2c;
  localparam int OPC_LSB  = 26;
  localparam int BASE_LSB = 21;
  localparam int SRC_LSB  = 16;
  localparam int ALIGN_BITS = 3;
  localparam logic [63:0] DATA_RST = 64'h0;
  // Exception codes reported with a refused store
  typedef enum logic [2:0] {
    DSU_EXC_NONE,
    DSU_EXC_TLB_REFILL,
    DSU_EXC_TLB_INVALID,
    DSU_EXC_TLB_MODIFIED,
    DSU_EXC_ADDR_ERR,
    DSU_EXC_RESERVED,
    DSU_EXC_COP_UNUSABLE,
    DSU_EXC_WATCH
  } dsu_exc_t;
  typedef enum logic [1:0] {
    DSU_K_INT,
    DSU_K_FLOAT,
    DSU_K_COP2,
    DSU_K_LEFT
  } dsu_kind_t;
endpackage

// >>> logic/dsu_store_unit.sv
// Execution stage for 64-bit stores: address, alignment, exceptions, lanes.
// Assumes operands are read in the issue cycle and the memory side returns
// translation faults in the same cycle as the translated address.
`timescale 1ns/1ps
module dsu_store_unit (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // Issue
  input  wire logic        issue_valid,
  input  wire logic [31:0] instr,
  input  wire logic [63:0] base_value,
  input  wire logic [63:0] general_register,
  input  wire logic [63:0] float_register,
  input  wire logic [63:0] cop2_register,
  input  wire logic        cop_usable,
  input  wire logic        core_order_big_flag,
  input  wire logic        memory_order_big_flag,
  input  wire logic        user_order_swap_flag,
  // Translation answer for the current effective target
  input  wire logic [63:0] phys_addr,
  input  wire logic [1:0]  coherency_attribute,
  input  wire logic        tlb_refill,
  input  wire logic        tlb_invalid,
  input  wire logic        tlb_modified,
  input  wire logic        watch_hit,
  // Address to translation
  output logic      [63:0] effective_target,
  // Memory write
  output logic             mem_we_q,
  output logic      [63:0] mem_addr_q,
  output logic      [63:0] mem_data_q,
  output logic      [7:0]  mem_lanes_q,
  output logic      [1:0]  mem_cca_q,
  // Exception report
  output logic             exc_valid_q,
  output dsu_pkg::dsu_exc_t exc_code_q
);
  logic [5:0]  opcode;
  logic [63:0] offset_ext;
  logic        is_int;
  logic        is_float;
  logic        is_cop2;
  logic        is_left;
  logic        is_cop;
  logic        misaligned;
  logic [63:0] left_data;
  logic [7:0]  left_lanes;
  logic [2:0]  phys_low;
  logic [2:0]  top_lane;
  dsu_pkg::dsu_exc_t exc_d;

  // Field decode
  assign opcode     = instr[31:dsu_pkg::OPC_LSB];
  assign offset_ext = {{48{instr[15]}}, instr[15:0]};
  assign is_int   = opcode == dsu_pkg::OP_STORE_DW;
  assign is_float = opcode == dsu_pkg::OP_FLOAT_DW;
  assign is_cop2  = opcode == dsu_pkg::OP_COP2_DW;
  assign is_left  = opcode == dsu_pkg::OP_LEFT_PART;
  assign is_cop   = is_float | is_cop2;

  // Translation sees the address combinationally; outputs below are registered
  assign effective_target = base_value + offset_ext;

  // Left-part store is exempt from alignment
  assign misaligned = (effective_target[dsu_pkg::ALIGN_BITS-1:0] != 3'h0)
                      & ~is_left;

  dsu_left_lanes dsu_left_lanes_inst (
    .low_addr            (effective_target[2:0]),
    .core_order_big_flag (core_order_big_flag),
    .src                 (general_register),
    .data                (left_data),
    .lanes               (left_lanes)
  );

  // Swap flag flips the low bits, little-endian memory clears them
  assign phys_low = memory_order_big_flag ?
                    (phys_addr[2:0] ^ {3{user_order_swap_flag}}) : 3'h0;

  // Lane that takes the top source byte; read only by the checks below
  assign top_lane = effective_target[2:0] ^ {3{core_order_big_flag}};

  // Priority: decode, unusable, alignment, translation, watch
  always_comb
  begin
    exc_d = dsu_pkg::DSU_EXC_NONE;
    if (!(is_int | is_cop | is_left))
      exc_d = dsu_pkg::DSU_EXC_RESERVED;
    else if (is_cop && !cop_usable)
      exc_d = dsu_pkg::DSU_EXC_COP_UNUSABLE;
    else if (misaligned)
      exc_d = dsu_pkg::DSU_EXC_ADDR_ERR;
    else if (tlb_refill)
      exc_d = dsu_pkg::DSU_EXC_TLB_REFILL;
    else if (tlb_invalid)
      exc_d = dsu_pkg::DSU_EXC_TLB_INVALID;
    else if (tlb_modified)
      exc_d = dsu_pkg::DSU_EXC_TLB_MODIFIED;
    else if (watch_hit)
      exc_d = dsu_pkg::DSU_EXC_WATCH;
  end

  // Exception report
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      exc_valid_q <= 1'b0;
      exc_code_q  <= dsu_pkg::DSU_EXC_NONE;
    end
    else
    begin
      exc_valid_q <= issue_valid && exc_d != dsu_pkg::DSU_EXC_NONE;
      exc_code_q  <= issue_valid ? exc_d : dsu_pkg::DSU_EXC_NONE;
    end
  end

  // Memory write; a faulting store never writes
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      mem_we_q    <= 1'b0;
      mem_addr_q  <= 64'h0;
      mem_data_q  <= dsu_pkg::DATA_RST;
      mem_lanes_q <= 8'h0;
      mem_cca_q   <= 2'h0;
    end
    else
    begin
      mem_we_q <= issue_valid && exc_d == dsu_pkg::DSU_EXC_NONE;
      if (issue_valid)
      begin
        mem_cca_q <= coherency_attribute;
        if (is_left)
        begin
          mem_addr_q  <= {phys_addr[63:3], phys_low};
          mem_data_q  <= left_data;
          mem_lanes_q <= left_lanes;
        end
        else
        begin
          mem_addr_q  <= phys_addr;
          mem_lanes_q <= 8'hff;
          if (is_float)
            mem_data_q <= float_register;
          else if (is_cop2)
            mem_data_q <= cop2_register;
          else
            mem_data_q <= general_register;
        end
      end
    end
  end

  // Assertions
  a_misaligned_no_write: assert property (@(posedge clk) disable iff (!rstn)
    issue_valid && is_int && effective_target[2:0] != 3'h0
    |=> !mem_we_q && exc_code_q == dsu_pkg::DSU_EXC_ADDR_ERR)
    else $error("misaligned integer store wrote");
  a_cop_align_err: assert property (@(posedge clk) disable iff (!rstn)
    issue_valid && is_cop && cop_usable && effective_target[2:0] != 3'h0
    |=> exc_valid_q && exc_code_q == dsu_pkg::DSU_EXC_ADDR_ERR)
    else $error("coprocessor misalignment missed");
  a_cop_unusable: assert property (@(posedge clk) disable iff (!rstn)
    issue_valid && is_cop && !cop_usable
    |=> exc_code_q == dsu_pkg::DSU_EXC_COP_UNUSABLE && !mem_we_q)
    else $error("unusable coprocessor not reported");
  a_left_no_align: assert property (@(posedge clk) disable iff (!rstn)
    issue_valid && is_left |=> exc_code_q != dsu_pkg::DSU_EXC_ADDR_ERR)
    else $error("left store raised address error");
  a_int_data_full: assert property (@(posedge clk) disable iff (!rstn)
    issue_valid && is_int && exc_d == dsu_pkg::DSU_EXC_NONE
    |=> mem_we_q && mem_lanes_q == 8'hff
        && mem_data_q == $past(general_register))
    else $error("integer store data wrong");
  a_float_data: assert property (@(posedge clk) disable iff (!rstn)
    issue_valid && is_float && exc_d == dsu_pkg::DSU_EXC_NONE
    |=> mem_data_q == $past(float_register))
    else $error("float store data wrong");
  a_cop2_data: assert property (@(posedge clk) disable iff (!rstn)
    issue_valid && is_cop2 && exc_d == dsu_pkg::DSU_EXC_NONE
    |=> mem_data_q == $past(cop2_register))
    else $error("cop2 store data wrong");
  a_eff_addr: assert property (@(posedge clk) disable iff (!rstn)
    effective_target - base_value == 64'($signed(instr[15:0])))
    else $error("effective address wrong");
  // Top source byte lands in the lane picked by address and core order
  a_left_lane_msb: assert property (@(posedge clk) disable iff (!rstn)
    issue_valid && is_left && exc_d == dsu_pkg::DSU_EXC_NONE
    |=> 8'(mem_data_q >> (8 * $past(top_lane))) == $past(general_register[63:56]))
    else $error("left store lost top byte");
  a_left_lane_mask: assert property (@(posedge clk) disable iff (!rstn)
    issue_valid && is_left && exc_d == dsu_pkg::DSU_EXC_NONE
    |=> mem_lanes_q == (8'hff >> (3'h7 - $past(top_lane))))
    else $error("left store lane mask wrong");
  a_left_phys_low: assert property (@(posedge clk) disable iff (!rstn)
    issue_valid && is_left && !memory_order_big_flag
    |=> mem_addr_q[2:0] == 3'h0)
    else $error("left store low bits not cleared");
  a_left_phys_swap: assert property (@(posedge clk) disable iff (!rstn)
    issue_valid && is_left && memory_order_big_flag
    |=> (mem_addr_q ^ $past(phys_addr)) == {61'h0, {3{$past(user_order_swap_flag)}}})
    else $error("left store low bits not swapped");
  a_aligned_addr: assert property (@(posedge clk) disable iff (!rstn)
    issue_valid && !is_left && exc_d == dsu_pkg::DSU_EXC_NONE
    |=> mem_addr_q == $past(phys_addr) && mem_lanes_q == 8'hff)
    else $error("aligned store address or lanes wrong");
  a_cca_follow: assert property (@(posedge clk) disable iff (!rstn)
    issue_valid |=> mem_cca_q == $past(coherency_attribute))
    else $error("store attribute not carried");
  // A store either writes or reports, never both, and only when issued
  a_we_exc_excl: assert property (@(posedge clk) disable iff (!rstn)
    !(mem_we_q && exc_valid_q))
    else $error("store wrote and faulted together");
  a_idle_quiet: assert property (@(posedge clk) disable iff (!rstn)
    !issue_valid
    |=> !mem_we_q && !exc_valid_q && exc_code_q == dsu_pkg::DSU_EXC_NONE)
    else $error("output pulse without an issue");
  a_reserved_op: assert property (@(posedge clk) disable iff (!rstn)
    issue_valid && opcode != dsu_pkg::OP_STORE_DW && opcode != dsu_pkg::OP_FLOAT_DW
    && opcode != dsu_pkg::OP_COP2_DW && opcode != dsu_pkg::OP_LEFT_PART
    |=> exc_valid_q && !mem_we_q && exc_code_q == dsu_pkg::DSU_EXC_RESERVED)
    else $error("unknown opcode not refused");
endmodule

// >>> sim/doubleword_store_unit_tb.sv
// Self-checking bench for the doubleword store unit.
// Assumes the translator model answers in the issue cycle.
`timescale 1ns/1ps
module doubleword_store_unit_tb;
  logic clk, rstn, issue_valid, usable, big, mb, swap, mem_we_q, exc_valid_q;
  logic [31:0] instr;
  logic [63:0] base_value, gr, fr, cr, ea, pa, pa_exp, mem_addr_q, mem_data_q;
  logic [1:0] cca, mem_cca_q;
  logic [3:0] fault, flags;
  logic [7:0] mem_lanes_q;
  dsu_pkg::dsu_exc_t exc_code_q;
  int fails, total_checks, cycles;
  dsu_xlate_model dsu_xlate_model_inst (.va(ea), .fault(fault), .pa(pa), .cca(cca),
    .flags(flags));
  dsu_store_unit dsu_store_unit_inst (.clk(clk), .rstn(rstn), .issue_valid(issue_valid),
    .instr(instr), .base_value(base_value), .general_register(gr), .float_register(fr),
    .cop2_register(cr), .cop_usable(usable), .core_order_big_flag(big),
    .memory_order_big_flag(mb), .user_order_swap_flag(swap), .phys_addr(pa),
    .coherency_attribute(cca), .tlb_refill(flags[0]), .tlb_invalid(flags[1]),
    .tlb_modified(flags[2]), .watch_hit(flags[3]), .effective_target(ea),
    .mem_we_q(mem_we_q), .mem_addr_q(mem_addr_q), .mem_data_q(mem_data_q),
    .mem_lanes_q(mem_lanes_q), .mem_cca_q(mem_cca_q), .exc_valid_q(exc_valid_q),
    .exc_code_q(exc_code_q));
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic summarize;
    $display("checks=%0d fails=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Hang guard: the whole run needs well under 3000 cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fails++;
      summarize();
    end
  end
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic logic [63:0] xpa(input logic [63:0] b, input logic [15:0] o);
    return (b + {{48{o[15]}}, o}) ^ 64'h0000_0a50_0000_0000;
  endfunction
  // m = {usable, core big, memory big, swap, fault[3:0]}
  task automatic iss(input logic [5:0] op, input logic [63:0] b, input logic [15:0] o,
    input logic [7:0] m);
    @(posedge clk);
    instr <= {op, 5'h3, 5'h7, o};
    base_value <= b;
    {usable, big, mb, swap} <= m[7:4];
    fault <= m[3:0];
    issue_valid <= 1'b1;
    @(posedge clk);
    issue_valid <= 1'b0;
    #1;
  endtask
  task automatic ok(input logic [63:0] a, input logic [63:0] d);
    chk(mem_we_q, 1'b1);
    chk(exc_valid_q, 1'b0);
    chk(mem_addr_q, a);
    chk(mem_data_q, d);
    chk(mem_lanes_q, 8'hff);
  endtask
  task automatic bad(input dsu_pkg::dsu_exc_t c);
    chk(exc_valid_q, 1'b1);
    chk(mem_we_q, 1'b0);
    chk(exc_code_q, c);
  endtask
  task automatic t_aligned;
    iss(dsu_pkg::OP_STORE_DW, 64'h1000, 16'hfff8, 8'h80);
    ok(xpa(64'h1000, 16'hfff8), gr);
    chk(mem_cca_q, 2'h3);
    iss(dsu_pkg::OP_FLOAT_DW, 64'h2000, 16'h0010, 8'h80);
    ok(xpa(64'h2000, 16'h0010), fr);
    iss(dsu_pkg::OP_COP2_DW, 64'h2000, 16'h0018, 8'h80);
    ok(xpa(64'h2000, 16'h0018), cr);
  endtask
  task automatic t_misalign;
    logic [17:0] ops;
    ops = {dsu_pkg::OP_STORE_DW, dsu_pkg::OP_FLOAT_DW, dsu_pkg::OP_COP2_DW};
    // A pending refill must not mask the alignment fault
    for (int j = 0; j < 3; j++)
      for (int k = 1; k < 8; k++)
      begin
        iss(ops[6*j +: 6], 64'h3000, k[15:0], 8'h81);
        bad(dsu_pkg::DSU_EXC_ADDR_ERR);
      end
  endtask
  task automatic t_faults;
    for (int k = 0; k < 4; k++)
    begin
      iss(dsu_pkg::OP_STORE_DW, 64'h5000, 16'h8, 8'h80 | (8'h1 << k));
      bad(k < 3 ? dsu_pkg::dsu_exc_t'(k + 1) : dsu_pkg::DSU_EXC_WATCH);
    end
    iss(dsu_pkg::OP_FLOAT_DW, 64'h5000, 16'h8, 8'h00);
    bad(dsu_pkg::DSU_EXC_COP_UNUSABLE);
    iss(6'h00, 64'h5000, 16'h8, 8'h80);
    bad(dsu_pkg::DSU_EXC_RESERVED);
    @(posedge clk);
    #1;
    chk(exc_code_q, dsu_pkg::DSU_EXC_NONE);
    chk(exc_valid_q, 1'b0);
  endtask
  task automatic t_left;
    logic [2:0] s;
    logic [15:0] ln;
    for (int i = 0; i < 64; i++)
    begin
      iss(dsu_pkg::OP_LEFT_PART, 64'h4000, {13'h0, i[2:0]}, {1'b1, i[5:3], 4'h0});
      s = i[2:0] ^ {3{i[5]}};
      ln = (16'h2 << s) - 16'h1;
      pa_exp = xpa(64'h4000, {13'h0, i[2:0]});
      pa_exp[2:0] = i[4] ? pa_exp[2:0] ^ {3{i[3]}} : 3'h0;
      chk(mem_we_q, 1'b1);
      chk(mem_lanes_q, ln[7:0]);
      chk(mem_data_q, gr >> (8 * (7 - s)));
      chk(mem_addr_q, pa_exp);
    end
  endtask
  initial
  begin
    {rstn, issue_valid, big, mb, swap} = 5'h0;
    usable = 1'b1;
    fault = 4'h0;
    instr = 32'h0;
    base_value = 64'h0;
    gr = 64'h0123_4567_89ab_cdef;
    fr = 64'hfedc_ba98_7654_3210;
    cr = 64'h5a69_7887_96a5_b4c3;
    repeat (2) @(posedge clk);
    #1;
    chk(mem_we_q, 1'b0);
    chk(exc_valid_q, 1'b0);
    chk(exc_code_q, dsu_pkg::DSU_EXC_NONE);
    chk(mem_lanes_q, 8'h0);
    @(posedge clk);
    rstn <= 1'b1;
    t_aligned();
    t_misalign();
    t_faults();
    t_left();
    summarize();
  end
endmodule

// >>> sim/dsu_xlate_model.sv
// Translator stand-in: fixed page remap, faults as the bench commands.
// Assumes the unit samples the answer in its issue cycle.
`timescale 1ns/1ps
module dsu_xlate_model (
  // Request
  input  wire logic [63:0] va,
  input  wire logic [3:0]  fault,
  // Answer
  output logic      [63:0] pa,
  output logic      [1:0]  cca,
  output logic      [3:0]  flags
);
  // Remap high bits so a leaked virtual address cannot pass
  assign pa    = va ^ 64'h0000_0a50_0000_0000;
  assign cca   = va[4:3];
  assign flags = fault;
endmodule
